// >>> ivpm_cfg.svh
/*
 * constants of the interrupt vector and power mode block: bus offsets,
 * vector addresses, priorities, flag positions.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef IVPM_CFG_SVH
`define IVPM_CFG_SVH

`define IVPM_OFS_MODE      4'h0
`define IVPM_OFS_IE        4'h1
`define IVPM_OFS_IFG       4'h2
`define IVPM_OFS_PORT1_PIN_EVENT_FLAGS     4'h3
`define IVPM_OFS_P1IE      4'h4
`define IVPM_OFS_GIE       4'h5
`define IVPM_OFS_RSTSRC    4'h6
`define IVPM_OFS_VEC       4'h7
`define IVPM_OFS_ISTAT     4'h8
`define IVPM_OFS_IMASK     4'h9
`define IVPM_OFS_TBL_BASE  4'ha
`define IVPM_VEC_TOP       17'h0ffff
`define IVPM_VEC_BOT       17'h0ffc0
`define IVPM_VEC_RESET     16'hfffe
`define IVPM_VEC_NMI       16'hfffc
`define IVPM_VEC_P1        16'hffe4
`define IVPM_PRIO_RESET    5'h1f
`define IVPM_PRIO_NMI      5'h1e
`define IVPM_PRIO_P1       5'h12
`define IVPM_ERASED        16'hffff
`define IVPM_P1_BONDED     8'he4
`define IVPM_PERIPH_TOP    16'h01ff
`define IVPM_IE_NMI        0
`define IVPM_IE_OF         1
`define IVPM_IE_ACCV       2
`define IVPM_IE_RST        0
`define IVPM_IE_POR        1
`define IVPM_IE_WDT        2
`define IVPM_IE_KEY        3
`define IVPM_IE_FETCH      4
`define IVPM_EV_WAKE       0
`define IVPM_EV_RESET      1
`define IVPM_EV_BLANK      2
`define IVPM_MODE_W        3

`endif

// >>> ivpm_pkg.sv
/*
 * types of the interrupt vector and power mode block.
 * assumes ivpm_cfg.svh on the include path.
 */
`include "ivpm_cfg.svh"

package ivpm_pkg;

	typedef enum logic [2:0] {
		full_run_mode,
		low_power_mode_0,
		low_power_mode_1,
		low_power_mode_2,
		low_power_mode_3,
		low_power_mode_4
	} ivpm_mode_type;

	typedef struct packed {
		logic cpu_on;
		logic main_clk_on;
		logic subsystem_clk_on;
		logic aux_clk_on;
		logic dco_gen_on;
		logic xtal_on;
	} ivpm_gate_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [4:0]  prio;
	} ivpm_vec_type;

endpackage : ivpm_pkg

// >>> ivpm_vec_mem.sv
/*
 * vector word store: 32 words covering the top-of-memory vector range.
 * assumes one clock; read data is registered, one cycle after the address.
 */
`timescale 1ns/100ps
`include "ivpm_cfg.svh"

module ivpm_vec_mem #(
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [15:0]   wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [15:0]   rdata_o
);

	// erased flash reads all ones until programmed
	logic [15:0] mem [DEPTH];

	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = `IVPM_ERASED;
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_o <= mem[raddr_i];
	end

endmodule : ivpm_vec_mem

// >>> ivpm_top.sv
/*
 * interrupt vectoring and low-power mode control, wishbone register slave.
 * assumes peripherals give one-cycle event pulses on clk_i, the core
 * takes vec_addr_o while vec_req_o is high and pulses ack/return.
 */
// Local design decisions: the placing of the registers and the Wishbone slave port.
// Summary of operation
// - one full run mode and five low-power modes, chosen by software
// - enabled interrupt wakes from any low-power mode; return restores it
// - full run mode: main, subsystem and auxiliary clocks all run
// - mode 0: cpu and main clock stop; auxiliary and subsystem run
// - mode 1: as mode 0; oscillator generator off unless used when active
// - mode 2: cpu, main, subsystem stop; generator and auxiliary stay on
// - mode 3: only auxiliary clock runs; generator off
// - mode 4: everything off, crystal oscillator halted
// - vectors and start address lie between 0x0ffc0 and 0x0ffff
// - each vector word holds the 16-bit handler address for the pc
// - erased reset vector after power-up sends the device into mode 4
// - pin event, oscillator fault, flash violation share 0xfffc, priority 30
// - port 1 bonded flags 2,5,6,7 share maskable vector 0xffe4, priority 18
// - fetch from peripheral region 0..01ff or unused range causes reset
// - nonmaskable sources obey own enable, ignore general enable
// - all eight port 1 flags exist in hardware
// - unused low vector words are ordinary memory
`timescale 1ns/100ps
`include "ivpm_cfg.svh"

module ivpm_top
	import ivpm_pkg::*;
#(
	parameter logic DCO_USED_ACTIVE = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        nmi_pin_i,
	input  wire logic        osc_fault_i,
	input  wire logic        flash_acc_viol_i,
	input  wire logic [7:0]  port1_event_i,
	input  wire logic        ext_reset_i,
	input  wire logic        watchdog_i,
	input  wire logic        flash_key_i,
	input  wire logic        fetch_valid_i,
	input  wire logic [15:0] fetch_addr_i,
	input  wire logic        fetch_unused_i,
	input  wire logic        vec_ack_i,
	input  wire logic        irq_return_i,
	output logic             vec_req_o,
	output logic      [15:0] vec_addr_o,
	output logic      [15:0] vec_pc_o,
	output logic             sys_reset_o,
	output ivpm_gate_type    gate_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser: three stages, change taken when stages two and three agree

	logic [2:0]    nmi_sync_reg;
	logic          nmi_level_reg;
	logic          nmi_rise;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_sync_reg  <= 3'h0;
			nmi_level_reg <= 1'b0;
		end else begin
			nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin_i};
			if (nmi_sync_reg[1] == nmi_sync_reg[2]) begin
				nmi_level_reg <= nmi_sync_reg[2];
			end
		end
	end

	assign nmi_rise = nmi_sync_reg[1] & nmi_sync_reg[2] & ~nmi_level_reg;

	////////////////////////////////////////////////////////////////////////
	// registers

	ivpm_mode_type mode_reg;
	ivpm_mode_type saved_mode_reg;
	logic [2:0]    ie_reg;
	logic [2:0]    ifg_reg;
	logic [7:0]    port1_pin_event_flags_reg;
	logic [7:0]    p1ie_reg;
	logic          gie_reg;
	logic [4:0]    rstsrc_reg;
	logic [2:0]    istat_reg;
	logic [2:0]    imask_reg;
	logic          in_handler_reg;
	logic          por_check_reg;
	logic          blank_wait_reg;
	ivpm_vec_type  pend;

	logic          wr;
	logic          rd;
	logic [3:0]    ofs;
	logic          fetch_bad;
	logic          any_reset;
	logic          take_nmi;
	logic          take_p1;
	logic [31:0]   rdata;
	logic [15:0]   mem_rdata;

	assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	assign rd  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign ofs = wb_adr_i[5:2];

	function automatic logic ofs_hit(input logic [3:0] o, input logic [3:0] k);
		return o == k;
	endfunction : ofs_hit

	assign fetch_bad = fetch_valid_i & (fetch_addr_i <= `IVPM_PERIPH_TOP | fetch_unused_i);
	assign any_reset = ext_reset_i | watchdog_i | flash_key_i | fetch_bad;

	// nonmaskable class ignores gie; port 1 needs gie
	assign take_nmi = |(ifg_reg & ie_reg);
	assign take_p1  = gie_reg & |(port1_pin_event_flags_reg & p1ie_reg & `IVPM_P1_BONDED);

	// fixed priority pick
	always_comb begin
		pend = '0;
		if (any_reset) begin
			pend = '{1'b1, `IVPM_VEC_RESET, `IVPM_PRIO_RESET};
		end else if (take_nmi) begin
			pend = '{1'b1, `IVPM_VEC_NMI, `IVPM_PRIO_NMI};
		end else if (take_p1) begin
			pend = '{1'b1, `IVPM_VEC_P1, `IVPM_PRIO_P1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operating mode and wake / restore

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg       <= full_run_mode;
			saved_mode_reg <= full_run_mode;
			in_handler_reg <= 1'b0;
		end else if (blank_wait_reg && mem_rdata == `IVPM_ERASED) begin
			mode_reg <= low_power_mode_4;
		end else if (wr && ofs_hit(ofs, `IVPM_OFS_MODE) && wb_dat_i[`IVPM_MODE_W-1:0] <= 3'h5) begin
			mode_reg <= ivpm_mode_type'(wb_dat_i[`IVPM_MODE_W-1:0]);
		end else if (vec_req_o && vec_ack_i) begin
			saved_mode_reg <= mode_reg;
			mode_reg       <= full_run_mode;
			in_handler_reg <= 1'b1;
		end else if (irq_return_i && in_handler_reg) begin
			mode_reg       <= saved_mode_reg;
			in_handler_reg <= 1'b0;
		end
	end

	// clock gates, registered straight to the port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			unique case (mode_reg)
				full_run_mode:    gate_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
				low_power_mode_0: gate_o <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
				low_power_mode_1: gate_o <= '{1'b0, 1'b0, 1'b1, 1'b1, DCO_USED_ACTIVE, 1'b1};
				low_power_mode_2: gate_o <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
				low_power_mode_3: gate_o <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
				low_power_mode_4: gate_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
				default:          gate_o <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power-up blank check of the reset vector

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			por_check_reg  <= 1'b1;
			blank_wait_reg <= 1'b0;
		end else begin
			por_check_reg  <= 1'b0;
			blank_wait_reg <= por_check_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags: hardware set wins over software clear

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ifg_reg   <= 3'h0;
			port1_pin_event_flags_reg <= 8'h00;
		end else begin
			if (wr && ofs_hit(ofs, `IVPM_OFS_IFG)) begin
				ifg_reg <= wb_dat_i[2:0] | {flash_acc_viol_i, osc_fault_i, nmi_rise};
			end else begin
				ifg_reg <= ifg_reg | {flash_acc_viol_i, osc_fault_i, nmi_rise};
			end
			if (wr && ofs_hit(ofs, `IVPM_OFS_PORT1_PIN_EVENT_FLAGS)) begin
				port1_pin_event_flags_reg <= wb_dat_i[7:0] | port1_event_i;
			end else begin
				port1_pin_event_flags_reg <= port1_pin_event_flags_reg | port1_event_i;
			end
		end
	end

	// reset source flags survive their own reset; power-up flag set at reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rstsrc_reg <= 5'h02;
		end else if (wr && ofs_hit(ofs, `IVPM_OFS_RSTSRC)) begin
			rstsrc_reg <= wb_dat_i[4:0] | {fetch_bad, flash_key_i, watchdog_i, 1'b0, ext_reset_i};
		end else begin
			rstsrc_reg <= rstsrc_reg | {fetch_bad, flash_key_i, watchdog_i, 1'b0, ext_reset_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_reg    <= 3'h0;
			p1ie_reg  <= 8'h00;
			gie_reg   <= 1'b0;
			imask_reg <= 3'h0;
		end else if (wr) begin
			if (ofs_hit(ofs, `IVPM_OFS_IE)) ie_reg <= wb_dat_i[2:0];
			if (ofs_hit(ofs, `IVPM_OFS_P1IE)) p1ie_reg <= wb_dat_i[7:0];
			if (ofs_hit(ofs, `IVPM_OFS_GIE)) gie_reg <= wb_dat_i[0];
			if (ofs_hit(ofs, `IVPM_OFS_IMASK)) imask_reg <= wb_dat_i[2:0];
		end
	end

	// software interrupt status: wake, reset, blank-vector events
	logic [2:0] ev;
	assign ev = {blank_wait_reg & (mem_rdata == `IVPM_ERASED), any_reset, vec_req_o & vec_ack_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			istat_reg <= 3'h0;
		end else if (wr && ofs_hit(ofs, `IVPM_OFS_ISTAT)) begin
			istat_reg <= (istat_reg & ~wb_dat_i[2:0]) | ev;
		end else begin
			istat_reg <= istat_reg | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) irq_o <= 1'b0;
		else irq_o <= |(istat_reg & imask_reg);
	end

	////////////////////////////////////////////////////////////////////////
	// vector fetch toward the core

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_req_o   <= 1'b0;
			vec_addr_o  <= `IVPM_VEC_RESET;
			sys_reset_o <= 1'b1;
		end else begin
			sys_reset_o <= any_reset;
			if (vec_req_o && vec_ack_i) begin
				vec_req_o <= 1'b0;
			end else if (!vec_req_o && pend.valid) begin
				vec_req_o  <= 1'b1;
				vec_addr_o <= pend.addr;
			end
		end
	end

	// vector word read: pc gets the stored handler address
	logic [4:0] mem_raddr;
	logic [4:0] mem_waddr;
	logic       mem_we;
	assign mem_raddr = (por_check_reg || blank_wait_reg) ? 5'h1f :
	                   vec_req_o ? vec_addr_o[5:1] : pend.addr[5:1];
	// low words 0xffc0-0xffde stay plain writable memory
	assign mem_we    = wr && ofs >= `IVPM_OFS_TBL_BASE && wb_adr_i[1:0] == 2'h0;
	assign mem_waddr = wb_dat_i[20:16];

	ivpm_vec_mem #(
		.DEPTH(32),
		.AW   (5)
	) u_vec_mem (
		.clk_i  (clk_i),
		.we_i   (mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(wb_dat_i[15:0]),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) vec_pc_o <= 16'h0000;
		else vec_pc_o <= mem_rdata;
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone read mux and ack

	always_comb begin
		rdata = 32'h0;
		unique case (ofs)
			`IVPM_OFS_MODE:   rdata = {29'h0, mode_reg};
			`IVPM_OFS_IE:     rdata = {29'h0, ie_reg};
			`IVPM_OFS_IFG:    rdata = {29'h0, ifg_reg};
			`IVPM_OFS_PORT1_PIN_EVENT_FLAGS:  rdata = {24'h0, port1_pin_event_flags_reg};
			`IVPM_OFS_P1IE:   rdata = {24'h0, p1ie_reg};
			`IVPM_OFS_GIE:    rdata = {31'h0, gie_reg};
			`IVPM_OFS_RSTSRC: rdata = {27'h0, rstsrc_reg};
			`IVPM_OFS_VEC:    rdata = {10'h0, pend.prio, in_handler_reg, vec_addr_o};
			`IVPM_OFS_ISTAT:  rdata = {29'h0, istat_reg};
			`IVPM_OFS_IMASK:  rdata = {29'h0, imask_reg};
			default:          rdata = {16'h0, mem_rdata};
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= rd;
			wb_dat_o <= rd ? rdata : 32'h0;
		end
	end

endmodule : ivpm_top

// >>> ivpm_top_props.sv
/*
 * port assertions of the interrupt vector and power mode block.
 * assumes one clock, sync active-high reset, bound by the statement at the foot.
 */
`timescale 1ns/100ps

module ivpm_top_props
	import ivpm_pkg::*;
(
	input wire logic          clk_i,
	input wire logic          rst_i,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_ack_o,
	input wire logic          ext_reset_i,
	input wire logic          watchdog_i,
	input wire logic          flash_key_i,
	input wire logic          fetch_valid_i,
	input wire logic [15:0]   fetch_addr_i,
	input wire logic          fetch_unused_i,
	input wire logic          vec_ack_i,
	input wire logic          vec_req_o,
	input wire logic [15:0]   vec_addr_o,
	input wire logic          sys_reset_o,
	input wire ivpm_gate_type gate_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after a bus request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_vec_hold: assert property (vec_req_o && !vec_ack_i |=> vec_req_o && $stable(vec_addr_o))
		else $error("vector request dropped or moved before ack");
	a_vec_word: assert property (vec_req_o |-> vec_addr_o inside {16'hfffe, 16'hfffc, 16'hffe4})
		else $error("vector word outside the served set");
	a_fetch_reset: assert property (fetch_valid_i && (fetch_addr_i <= 16'h01ff || fetch_unused_i) |-> ##[1:2] sys_reset_o)
		else $error("bad fetch gave no reset");
	a_cause_reset: assert property (ext_reset_i || watchdog_i || flash_key_i |-> ##[1:2] sys_reset_o)
		else $error("reset cause gave no reset");
	a_ack_wakes: assert property (vec_req_o && vec_ack_i |-> ##[1:2] gate_o == 6'h3f)
		else $error("taken vector did not wake all clocks");
	a_cpu_main: assert property (gate_o.cpu_on == gate_o.main_clk_on)
		else $error("cpu and main clock gated apart");
	a_gate_shape: assert property (gate_o inside {6'h3f, 6'h0f, 6'h0d, 6'h07, 6'h05, 6'h00})
		else $error("clock gate pattern of no mode");
	a_reset_run: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> gate_o == 6'h3f)
		else $error("reset did not run all clocks");

	c_port1_vec: cover property (vec_req_o && vec_addr_o == 16'hffe4);
	c_deep_sleep: cover property (gate_o == 6'h00);
	c_wake: cover property (vec_req_o && vec_ack_i);
endmodule : ivpm_top_props

////////////////////////////////////////
bind ivpm_top ivpm_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_reset_i(ext_reset_i), .watchdog_i(watchdog_i),
	.flash_key_i(flash_key_i), .fetch_valid_i(fetch_valid_i), .fetch_addr_i(fetch_addr_i),
	.fetch_unused_i(fetch_unused_i), .vec_ack_i(vec_ack_i), .vec_req_o(vec_req_o),
	.vec_addr_o(vec_addr_o), .sys_reset_o(sys_reset_o), .gate_o(gate_o));

// >>> ivpm_core_model.sv
/*
 * core model: takes a vector after a chosen delay, returns after a fixed handler.
 * assumes the request is a level held until the ack edge.
 */
`timescale 1ns/100ps

module ivpm_core_model #(
	parameter int HANDLER = 24
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       vec_req_i,
	input  wire logic [3:0] delay_i,
	output logic            vec_ack_o,
	output logic            irq_return_o
);
	logic [7:0] cnt_reg;
	logic       busy_reg;

	// no second vector taken while a handler runs
	always_ff @(posedge clk_i) begin
		vec_ack_o    <= 1'b0;
		irq_return_o <= 1'b0;
		if (rst_i) begin
			cnt_reg  <= 8'h00;
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg + 8'h01;
			if (cnt_reg == 8'(HANDLER)) begin
				irq_return_o <= 1'b1;
				busy_reg     <= 1'b0;
				cnt_reg      <= 8'h00;
			end
		end else if (vec_req_i && !vec_ack_o) begin
			cnt_reg <= cnt_reg + 8'h01;
			if (cnt_reg >= {4'h0, delay_i}) begin
				vec_ack_o <= 1'b1;
				busy_reg  <= 1'b1;
				cnt_reg   <= 8'h00;
			end
		end
	end
endmodule : ivpm_core_model

// >>> tb_top.sv
/*
 * self-checking bench of the interrupt vector and power mode block.
 * assumes ivpm_pkg, the checker and the core model compiled before it.
 */
`timescale 1ns/100ps

module tb_top;
	logic        clk_i, rst_i, cyc, stb, we, ack, fv, fu, vack, iret, vreq, sysr, irq;
	logic [2:0]  ev, rc;
	logic [3:0]  dly;
	logic [5:0]  adr, gate;
	logic [7:0]  p1;
	logic [15:0] fa, vaddr, vpc, vn, vp;
	logic [31:0] dw, dr, rd;
	int          fails, compares;

	ivpm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.nmi_pin_i(ev[0]), .osc_fault_i(ev[1]), .flash_acc_viol_i(ev[2]), .port1_event_i(p1),
		.ext_reset_i(rc[0]), .watchdog_i(rc[1]), .flash_key_i(rc[2]), .fetch_valid_i(fv),
		.fetch_addr_i(fa), .fetch_unused_i(fu), .vec_ack_i(vack), .irq_return_i(iret),
		.vec_req_o(vreq), .vec_addr_o(vaddr), .vec_pc_o(vpc), .sys_reset_o(sysr), .gate_o(gate), .irq_o(irq));
	ivpm_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .vec_req_i(vreq), .delay_i(dly),
		.vec_ack_o(vack), .irq_return_o(iret));

	always #5 clk_i = ~clk_i;

	////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dw  <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			fails++;
			tally_and_finish();
		end
	endtask : wb

	task automatic wait_vreq(input logic lvl);
		int n;
		n = 0;
		while (vreq !== lvl && n < 80) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 80) begin
			fails++;
			tally_and_finish();
		end
	endtask : wait_vreq

	task automatic pulse(input logic [2:0] e, input logic [2:0] r, input logic [7:0] p);
		@(posedge clk_i);
		ev <= e;
		rc <= r;
		p1 <= p;
		// the pin passes a three-stage filter: a one-cycle blip would be dropped
		repeat (3) @(posedge clk_i);
		ev <= 3'h0;
		rc <= 3'h0;
		p1 <= 8'h00;
	endtask : pulse

	task automatic reset_pulse;
		rst_i <= 1'b1;
		tick(3);
		rst_i <= 1'b0;
		tick(6);
	endtask : reset_pulse

	// gate order {cpu, main, subsys, aux, dco_gen, xtal}
	function automatic logic [31:0] gate_of(input int m);
		case (m)
			0: return 32'h3f;
			1, 2: return 32'h0f;
			3: return 32'h07;
			4: return 32'h05;
			default: return 32'h00;
		endcase
	endfunction : gate_of

	////////////////////////////////////////
	initial begin
		logic [4:0]  re [6];
		logic [31:0] bw;
		re = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h10, 5'h00};
		bw = 32'h80402004;
		{clk_i, cyc, stb, we, fv, fu} = 6'h00;
		rst_i = 1'b1;
		{ev, rc, dly, adr, p1, fa, dw} = 72'h0;
		fails = 0;
		compares = 0;
		void'($urandom(3));
		vn = 16'($urandom);
		vp = 16'($urandom);
		tick(3);
		rst_i <= 1'b0;
		tick(1);
		wb(1'b1, 6'h28, {11'h0, 5'h1e, vn});
		wb(1'b1, 6'h28, {11'h0, 5'h12, vp});
		wb(1'b1, 6'h28, {11'h0, 5'h1f, 16'hc000});
		for (int m = 0; m < 6; m++) begin
			wb(1'b1, 6'h00, 32'(m));
			tick(2);
			check(32'(gate), gate_of(m));
			wb(1'b0, 6'h00, 32'h0);
			check(32'(rd[2:0]), 32'(m));
		end
		// out-of-range mode is refused, deepest mode stays
		wb(1'b1, 6'h00, 32'h6);
		tick(2);
		check(32'(gate), 32'h00);
		wb(1'b1, 6'h04, 32'h7);
		for (int s = 0; s < 3; s++) begin
			wb(1'b1, 6'h00, 32'h4);
			dly <= 4'($urandom_range(3, 9));
			pulse(3'(1 << s), 3'h0, 8'h00);
			wait_vreq(1'b1);
			check(32'(vaddr), 32'hfffc);
			wb(1'b1, 6'h08, 32'h0);
			check(32'(vpc), 32'(vn));
			wait_vreq(1'b0);
			tick(2);
			check(32'(gate), 32'h3f);
			tick(30);
			check(32'(gate), 32'h05);
		end
		// own enable alone blocks the nonmaskable class
		wb(1'b1, 6'h04, 32'h5);
		pulse(3'h2, 3'h0, 8'h00);
		tick(8);
		check(32'(vreq), 32'h0);
		wb(1'b1, 6'h08, 32'h0);
		wb(1'b1, 6'h04, 32'h7);
		wb(1'b1, 6'h24, 32'h0);
		tick(2);
		check(32'(irq), 32'h0);
		wb(1'b1, 6'h24, 32'h1);
		tick(2);
		check(32'(irq), 32'h1);
		wb(1'b1, 6'h20, 32'h1);
		tick(2);
		check(32'(irq), 32'h0);
		wb(1'b1, 6'h00, 32'h0);
		wb(1'b1, 6'h10, 32'hff);
		pulse(3'h0, 3'h0, 8'h21);
		tick(8);
		check(32'(vreq), 32'h0);
		wb(1'b0, 6'h0c, 32'h0);
		check(32'(rd[7:0]), 32'h21);
		wb(1'b1, 6'h0c, 32'h0);
		wb(1'b1, 6'h14, 32'h1);
		pulse(3'h2, 3'h0, bw[8 * $urandom_range(0, 3) +: 8]);
		wait_vreq(1'b1);
		check(32'(vaddr), 32'hfffc);
		wb(1'b1, 6'h08, 32'h0);
		wait_vreq(1'b0);
		wait_vreq(1'b1);
		check(32'(vaddr), 32'hffe4);
		wb(1'b1, 6'h0c, 32'h0);
		check(32'(vpc), 32'(vp));
		tick(70);
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, 6'h18, 32'h0);
			@(posedge clk_i);
			fv <= i > 2;
			fa <= (i == 3) ? 16'h01ff : 16'hc000;
			fu <= i == 4;
			rc <= (i < 3) ? 3'(1 << i) : 3'h0;
			@(posedge clk_i);
			fv <= 1'b0;
			rc <= 3'h0;
			tick(3);
			wb(1'b0, 6'h18, 32'h0);
			check(32'(rd[4:0] & (i == 5 ? 5'h1f : re[i])), 32'(re[i]));
		end
		// erased reset word sends the next start into the deepest mode
		wb(1'b1, 6'h28, {11'h0, 5'h1f, 16'hffff});
		reset_pulse();
		check(32'(gate), 32'h00);
		wb(1'b1, 6'h28, {11'h0, 5'h1f, 16'h7fff & vn});
		reset_pulse();
		check(32'(gate), 32'h3f);
		tally_and_finish();
	end
endmodule : tb_top
